// file: core_addressing_mode_decoder.sv
`timescale 1ns/1ps
module core_addressing_mode_decoder #(
   parameter logic [11:0] START_PC = core_pkg::RESET_PC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] prog_data,
   input wire logic [7:0] data_rdata,
   output core_pkg::prog_req_type prog_req_ff,
   output core_pkg::data_req_type data_req_ff,
   output core_pkg::flags_type flags_ff,
   output logic [7:0] acc_ff,
   output logic unsupported_ff
);

   function automatic core_pkg::op_class_type classify(input logic [7:0] op);
      core_pkg::op_class_type c;
      c = core_pkg::CLS_UNSUPPORTED;
      if (!op[7]) begin
         c = core_pkg::CLS_RELATIVE;
      end else begin
         unique case (op[7:4])
            core_pkg::OPG_LONG_JUMP: c = core_pkg::CLS_LONG_JUMP;
            core_pkg::OPG_CALL: c = core_pkg::CLS_CALL;
            core_pkg::OPG_BIT_SET_CLEAR: c = core_pkg::CLS_BIT_SET_CLEAR;
            core_pkg::OPG_BIT_TEST: c = core_pkg::CLS_BIT_TEST;
            core_pkg::OPG_MOVE_ONE: begin
               if (op[3:0] <= core_pkg::MV_LOAD_IMM_MEM) begin
                  c = core_pkg::CLS_MOVE;
               end
            end
            core_pkg::OPG_MOVE_TWO: begin
               if (op[3:1] == core_pkg::MV_LOAD_INDIRECT[3:1]) begin
                  c = core_pkg::CLS_MOVE;
               end
            end
            core_pkg::OPG_INHERENT: begin
               if (op[3:0] <= core_pkg::INH_LAST) begin
                  c = core_pkg::CLS_INHERENT;
               end
            end
            default: c = core_pkg::CLS_UNSUPPORTED;
         endcase
      end
      return c;
   endfunction : classify

   function automatic logic [2:0] cycles_of(input logic [7:0] op);
      logic [2:0] n;
      unique case (classify(op))
         core_pkg::CLS_BIT_TEST: n = core_pkg::CYC_BIT_TEST;
         core_pkg::CLS_LONG_JUMP,
         core_pkg::CLS_CALL,
         core_pkg::CLS_BIT_SET_CLEAR,
         core_pkg::CLS_MOVE: n = core_pkg::CYC_MEMORY;
         default: n = core_pkg::CYC_CONTROL;
      endcase
      return n;
   endfunction : cycles_of

   function automatic logic [11:0] length_of(input logic [7:0] op);
      logic [11:0] n;
      unique case (classify(op))
         core_pkg::CLS_LONG_JUMP,
         core_pkg::CLS_CALL,
         core_pkg::CLS_BIT_SET_CLEAR: n = core_pkg::LEN_TWO;
         core_pkg::CLS_BIT_TEST: n = core_pkg::LEN_THREE;
         core_pkg::CLS_MOVE: begin
            if (op[3:0] == core_pkg::MV_LOAD_IMM_MEM) begin
               n = core_pkg::LEN_THREE;
            end else if (op[3:0] == core_pkg::MV_LOAD_DIRECT ||
                         op[3:0] == core_pkg::MV_STORE_DIRECT ||
                         op[3:0] == core_pkg::MV_LOAD_IMM_ACC) begin
               n = core_pkg::LEN_TWO;
            end else begin
               n = core_pkg::LEN_ONE;
            end
         end
         default: n = core_pkg::LEN_ONE;
      endcase
      return n;
   endfunction : length_of

   function automatic logic core_hit(input logic [7:0] a);
      return (a == core_pkg::ACC_ADDR) || (a[7:2] == core_pkg::PTR_ONE_ADDR[7:2]);
   endfunction : core_hit

   core_pkg::state_type state_ff;
   logic [2:0] cyc_ff;
   logic [11:0] ipc_ff;
   logic [7:0] op_ff;
   logic [7:0] byte2_ff;
   logic [7:0] byte3_ff;
   logic [7:0] ptr_one_ff;
   logic [7:0] ptr_two_ff;
   logic [7:0] sreg_three_ff;
   logic [7:0] sreg_four_ff;

   logic in_run;
   logic [7:0] op_cur;
   core_pkg::op_class_type op_class;
   logic [3:0] sub;
   logic [2:0] bit_sel;
   logic [2:0] need;
   logic fetch_now;
   logic last_cyc;
   logic exec_cyc;
   logic [2:0] nxt_cyc;
   logic is_move;
   logic is_load_acc;
   logic is_store;
   logic is_load_imm_acc;
   logic is_load_imm_mem;
   logic is_bit_op;
   logic is_bit_test;
   logic is_ret;
   logic need_read;
   logic [7:0] eff_addr;
   logic [7:0] core_val;
   logic [7:0] rd_val;
   logic tested;
   logic [7:0] bit_mask;
   logic [7:0] bit_new;
   logic do_write;
   logic wr_core;
   logic [7:0] wr_val;
   logic [7:0] load_val;
   logic flag_sel;
   logic rel_cond;
   logic [11:0] rel_target;
   logic [11:0] ext_target;
   logic [11:0] btb_target;
   logic [11:0] seq_pc;
   logic [11:0] stack_top;
   logic [11:0] next_pc;
   core_pkg::prog_req_type nxt_prog_req;
   core_pkg::data_req_type nxt_data_req;

   assign in_run = (state_ff == core_pkg::S_RUN);
   assign op_cur = (cyc_ff == 3'h0) ? prog_data : op_ff;
   assign op_class = classify(op_cur);
   assign sub = op_cur[3:0];
   assign bit_sel = op_cur[2:0];
   assign need = cycles_of(op_cur);
   assign fetch_now = in_run && (cyc_ff == need - 3'h2);
   assign last_cyc = in_run && (cyc_ff == need - 3'h1);
   assign exec_cyc = in_run && (cyc_ff == core_pkg::CYC_EXEC);
   assign nxt_cyc = (!in_run || last_cyc) ? 3'h0 : cyc_ff + 3'h1;

   assign is_move = (op_class == core_pkg::CLS_MOVE);
   assign is_load_acc = is_move && (sub[3:2] == 2'h0 || sub == core_pkg::MV_LOAD_DIRECT ||
                                    sub == core_pkg::MV_LOAD_INDIRECT);
   assign is_store = is_move && (sub[3:2] == 2'h1 || sub == core_pkg::MV_STORE_DIRECT ||
                                 sub == core_pkg::MV_STORE_INDIRECT);
   assign is_load_imm_acc = is_move && (sub == core_pkg::MV_LOAD_IMM_ACC);
   assign is_load_imm_mem = is_move && (sub == core_pkg::MV_LOAD_IMM_MEM);
   assign is_bit_op = (op_class == core_pkg::CLS_BIT_SET_CLEAR);
   assign is_bit_test = (op_class == core_pkg::CLS_BIT_TEST);
   assign is_ret = (op_class == core_pkg::CLS_INHERENT) &&
                   (sub == core_pkg::INH_RET || sub == core_pkg::INH_RETI);
   assign need_read = is_load_acc || is_bit_op || is_bit_test;

   // Address settles in cycle 1, when the second program byte is on the bus
   assign eff_addr = (is_move && sub[3] == 1'b0) ?
                        (core_pkg::PTR_ONE_ADDR | {6'h00, sub[1:0]}) :
                     (is_move && sub[3:1] == core_pkg::MV_LOAD_INDIRECT[3:1]) ?
                        (op_cur[4] ? ptr_two_ff : ptr_one_ff) :
                     prog_data;

   assign core_val = (data_req_ff.addr == core_pkg::ACC_ADDR) ? acc_ff :
                     (data_req_ff.addr == core_pkg::PTR_ONE_ADDR) ? ptr_one_ff :
                     (data_req_ff.addr == core_pkg::PTR_TWO_ADDR) ? ptr_two_ff :
                     (data_req_ff.addr == core_pkg::SREG_THREE_ADDR) ? sreg_three_ff :
                     sreg_four_ff;
   assign rd_val = core_hit(data_req_ff.addr) ? core_val : data_rdata;
   assign tested = rd_val[bit_sel];
   assign bit_mask = 8'h01 << bit_sel;
   assign bit_new = op_cur[3] ? (rd_val | bit_mask) : (rd_val & ~bit_mask);

   assign do_write = exec_cyc && (is_store || is_load_imm_mem || is_bit_op);
   assign wr_core = do_write && core_hit(data_req_ff.addr);
   assign wr_val = is_store ? acc_ff : (is_load_imm_mem ? byte3_ff : bit_new);
   assign load_val = is_load_imm_acc ? byte2_ff : rd_val;

   assign flag_sel = op_cur[6] ? flags_ff.carry : flags_ff.zero;
   assign rel_cond = (op_class == core_pkg::CLS_RELATIVE) && (flag_sel == op_cur[5]);
   assign rel_target = op_cur[4] ? (ipc_ff - {8'h00, op_cur[3:0]}) :
                       (ipc_ff + {8'h00, op_cur[3:0]} + 12'h001);
   assign ext_target = {op_cur[3:0], byte2_ff};
   assign btb_target = ipc_ff + 12'h001 + {{4{byte3_ff[7]}}, byte3_ff};
   assign seq_pc = ipc_ff + length_of(op_cur);

   assign next_pc = rel_cond ? rel_target :
                    (op_class == core_pkg::CLS_LONG_JUMP ||
                     op_class == core_pkg::CLS_CALL) ? ext_target :
                    (is_bit_test && tested == op_cur[3]) ? btb_target :
                    is_ret ? stack_top :
                    seq_pc;

   // Prefetch runs one byte ahead; a wasted read costs nothing here
   assign nxt_prog_req.rd = 1'b1;
   assign nxt_prog_req.addr = fetch_now ? next_pc :
                              (ipc_ff + {9'h000, nxt_cyc} + 12'h001);

   assign nxt_data_req.rd = in_run && (cyc_ff == 3'h1) && need_read && !core_hit(eff_addr);
   assign nxt_data_req.wr = do_write && !wr_core;
   assign nxt_data_req.addr = (in_run && cyc_ff == 3'h1) ? eff_addr : data_req_ff.addr;
   assign nxt_data_req.wdata = do_write ? wr_val : data_req_ff.wdata;

   return_stack #(
      .DEPTH(core_pkg::STACK_DEPTH),
      .WIDTH(core_pkg::PC_W)
   ) u_return_stack (
      .core_clk(core_clk),
      .rst(rst),
      .push(fetch_now && op_class == core_pkg::CLS_CALL),
      .pop(fetch_now && is_ret),
      .push_data(seq_pc),
      .top(stack_top)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= core_pkg::S_BOOT;
         cyc_ff <= 3'h0;
         ipc_ff <= START_PC;
      end else begin
         state_ff <= core_pkg::S_RUN;
         cyc_ff <= nxt_cyc;
         if (fetch_now) begin
            ipc_ff <= next_pc;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prog_req_ff <= '{rd: 1'b1, addr: START_PC};
         data_req_ff <= '0;
         unsupported_ff <= 1'b0;
      end else begin
         prog_req_ff <= nxt_prog_req;
         data_req_ff <= nxt_data_req;
         unsupported_ff <= in_run && (cyc_ff == 3'h0) &&
                           (op_class == core_pkg::CLS_UNSUPPORTED);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         op_ff <= 8'h00;
         byte2_ff <= 8'h00;
         byte3_ff <= 8'h00;
      end else if (in_run) begin
         if (cyc_ff == 3'h0) begin
            op_ff <= prog_data;
         end
         if (cyc_ff == 3'h1) begin
            byte2_ff <= prog_data;
         end
         if (cyc_ff == 3'h2) begin
            byte3_ff <= prog_data;
         end
      end
   end

   // Zero follows the moved value; immediate-to-memory leaves both flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_ff <= '0;
      end else if (exec_cyc) begin
         if (is_load_acc || is_load_imm_acc) begin
            flags_ff.zero <= (load_val == 8'h00);
         end else if (is_store) begin
            flags_ff.zero <= (acc_ff == 8'h00);
         end else if (is_bit_op || is_bit_test) begin
            flags_ff.carry <= tested;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_ff <= core_pkg::REG_RESET;
      end else if (exec_cyc && (is_load_acc || is_load_imm_acc)) begin
         acc_ff <= load_val;
      end else if (wr_core && data_req_ff.addr == core_pkg::ACC_ADDR) begin
         acc_ff <= wr_val;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ptr_one_ff <= core_pkg::REG_RESET;
         ptr_two_ff <= core_pkg::REG_RESET;
         sreg_three_ff <= core_pkg::REG_RESET;
         sreg_four_ff <= core_pkg::REG_RESET;
      end else if (wr_core) begin
         unique case (data_req_ff.addr)
            core_pkg::PTR_ONE_ADDR: ptr_one_ff <= wr_val;
            core_pkg::PTR_TWO_ADDR: ptr_two_ff <= wr_val;
            core_pkg::SREG_THREE_ADDR: sreg_three_ff <= wr_val;
            core_pkg::SREG_FOUR_ADDR: sreg_four_ff <= wr_val;
            default: ;
         endcase
      end
   end

endmodule : core_addressing_mode_decoder

// file: core_pkg.sv
package core_pkg;

   localparam int PC_W = 12;
   localparam int DATA_W = 8;
   localparam int STACK_DEPTH = 6;

   localparam logic [11:0] RESET_PC = 12'h000;

   // Data-space homes of the core registers
   localparam logic [7:0] PTR_ONE_ADDR = 8'h80;
   localparam logic [7:0] PTR_TWO_ADDR = 8'h81;
   localparam logic [7:0] SREG_THREE_ADDR = 8'h82;
   localparam logic [7:0] SREG_FOUR_ADDR = 8'h83;
   localparam logic [7:0] ACC_ADDR = 8'hff;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Opcode groups, upper nibble
   localparam logic [3:0] OPG_LONG_JUMP = 4'h8;
   localparam logic [3:0] OPG_CALL = 4'h9;
   localparam logic [3:0] OPG_BIT_SET_CLEAR = 4'ha;
   localparam logic [3:0] OPG_BIT_TEST = 4'hb;
   localparam logic [3:0] OPG_MOVE_ONE = 4'hc;
   localparam logic [3:0] OPG_MOVE_TWO = 4'hd;
   localparam logic [3:0] OPG_INHERENT = 4'he;

   // Move group, lower nibble
   localparam logic [3:0] MV_LOAD_DIRECT = 4'h8;
   localparam logic [3:0] MV_STORE_DIRECT = 4'h9;
   localparam logic [3:0] MV_LOAD_INDIRECT = 4'ha;
   localparam logic [3:0] MV_STORE_INDIRECT = 4'hb;
   localparam logic [3:0] MV_LOAD_IMM_ACC = 4'hc;
   localparam logic [3:0] MV_LOAD_IMM_MEM = 4'hd;

   // Inherent group, lower nibble
   localparam logic [3:0] INH_NOP = 4'h0;
   localparam logic [3:0] INH_RET = 4'h1;
   localparam logic [3:0] INH_RETI = 4'h2;
   localparam logic [3:0] INH_LAST = 4'h4;

   // Instruction lengths in bytes
   localparam logic [11:0] LEN_ONE = 12'h001;
   localparam logic [11:0] LEN_TWO = 12'h002;
   localparam logic [11:0] LEN_THREE = 12'h003;

   // Instruction cycle counts, and the index of the execute cycle
   localparam logic [2:0] CYC_CONTROL = 3'h2;
   localparam logic [2:0] CYC_MEMORY = 3'h4;
   localparam logic [2:0] CYC_BIT_TEST = 3'h5;
   localparam logic [2:0] CYC_EXEC = 3'h3;

   typedef enum logic [2:0] {
      CLS_RELATIVE,
      CLS_LONG_JUMP,
      CLS_CALL,
      CLS_BIT_SET_CLEAR,
      CLS_BIT_TEST,
      CLS_MOVE,
      CLS_INHERENT,
      CLS_UNSUPPORTED
   } op_class_type;

   typedef enum logic [1:0] {
      S_BOOT = 2'b01,
      S_RUN = 2'b10
   } state_type;

   typedef struct packed {
      logic rd;
      logic [11:0] addr;
   } prog_req_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } data_req_type;

   typedef struct packed {
      logic zero;
      logic carry;
   } flags_type;

endpackage : core_pkg

// file: return_stack.sv
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = 6,
   parameter int WIDTH = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] cell_ff [DEPTH];
   logic [PTR_W-1:0] ptr_ff;
   logic [PTR_W-1:0] ptr_up;
   logic [PTR_W-1:0] ptr_down;

   // Circular: a seventh push silently overwrites the oldest entry
   assign ptr_up = (ptr_ff == LAST) ? '0 : ptr_ff + PTR_W'(1);
   assign ptr_down = (ptr_ff == '0) ? LAST : ptr_ff - PTR_W'(1);
   assign top = cell_ff[ptr_down];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ptr_ff <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            cell_ff[i] <= '0;
         end
      end else if (push) begin
         cell_ff[ptr_ff] <= push_data;
         ptr_ff <= ptr_up;
      end else if (pop) begin
         ptr_ff <= ptr_down;
      end
   end

endmodule : return_stack

// file: core_monitor.sv
`timescale 1ns/1ps
module core_monitor #(
   parameter logic [11:0] START_PC = 12'h000
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] prog_data,
   input wire logic [7:0] data_rdata,
   input wire core_pkg::prog_req_type prog_req_ff,
   input wire core_pkg::data_req_type data_req_ff,
   input wire core_pkg::flags_type flags_ff,
   input wire logic [7:0] acc_ff,
   input wire logic unsupported_ff
);
   logic boot_ff;
   logic [2:0] ph_ff;
   logic [2:0] len_ff;
   logic [7:0] op_ff;
   // Tracks opcode cycles from the ports alone
   function automatic logic [2:0] cyc(input logic [7:0] op);
      case (op[7:4])
         4'h8, 4'h9, 4'ha: return 3'h4;
         4'hb: return 3'h5;
         4'hc: return (op[3:0] < 4'he) ? 3'h4 : 3'h2;
         4'hd: return (op[3:1] == 3'h5) ? 3'h4 : 3'h2;
         default: return 3'h2;
      endcase
   endfunction : cyc
   wire opc = !boot_ff && ph_ff == 3'h0;
   wire [2:0] cur_len = opc ? cyc(prog_data) : len_ff;
   wire [11:0] pc = prog_req_ff.addr;
   wire [11:0] span = {8'h00, prog_data[3:0]};
   wire take = (prog_data[6] ? flags_ff.carry : flags_ff.zero) == prog_data[5];
   wire [11:0] rel_tgt = !take ? pc : prog_data[4] ? pc - 12'h001 - span : pc + span;
   wire [7:0] msk = 8'h01 << op_ff[2:0];
   wire [7:0] da = data_req_ff.addr;
   wire core_reg = da[7:2] == 6'h20 || da == 8'hff;
   wire inh_ok = prog_data[7:4] == 4'he && prog_data[3:0] < 4'h5;
   wire bad_op = prog_data[7] && cyc(prog_data) == 3'h2 && !inh_ok;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         boot_ff <= 1'b1;
         ph_ff <= 3'h0;
      end else begin
         boot_ff <= 1'b0;
         if (!boot_ff)
            ph_ff <= (ph_ff == cur_len - 3'h1) ? 3'h0 : ph_ff + 3'h1;
         if (opc) begin
            op_ff <= prog_data;
            len_ff <= cur_len;
         end
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_load_dir;
      opc && prog_data == 8'hc8 ##1 !prog_data[7];
   endsequence
   sequence s_bit_op;
      opc && prog_data[7:4] == 4'ha ##1 !prog_data[7];
   endsequence
   sequence s_bit_test;
      opc && prog_data[7:4] == 4'hb ##1 !prog_data[7];
   endsequence
   a_reset_state: assert property ($fell(rst) |-> pc == START_PC && acc_ff == 8'h00 &&
      flags_ff == 2'b00 && !unsupported_ff) else $error("state after reset wrong");
   a_prog_read_on: assert property (prog_req_ff.rd) else $error("program read dropped");
   a_core_regs_inside: assert property ((data_req_ff.rd || data_req_ff.wr) |->
      !core_reg) else $error("core register sent to bus");
   a_read_spacing: assert property (data_req_ff.rd |=> !data_req_ff.rd [*3])
      else $error("reads too close");
   a_load_direct: assert property (s_load_dir |=> data_req_ff.rd &&
      da == $past(prog_data) ##2 acc_ff == $past(data_rdata) &&
      flags_ff.zero == (acc_ff == 8'h00) && flags_ff.carry == $past(flags_ff.carry, 3))
      else $error("direct load wrong");
   a_bit_carry: assert property (s_bit_op |=> data_req_ff.rd ##2 data_req_ff.wr &&
      data_req_ff.wdata == (op_ff[3] ? $past(data_rdata) | msk : $past(data_rdata) & ~msk)
      && flags_ff.carry == |($past(data_rdata) & msk)) else $error("bit set or clear wrong");
   a_bit_test: assert property (s_bit_test |=> data_req_ff.rd ##3
      flags_ff.carry == |($past(data_rdata, 2) & msk) &&
      flags_ff.zero == $past(flags_ff.zero, 4)) else $error("bit test flags wrong");
   a_rel_target: assert property (opc && !prog_data[7] |=> pc == $past(rel_tgt))
      else $error("relative branch address wrong");
   a_jump_target: assert property (opc && prog_data[7:4] == 4'h8 |->
      ##3 pc == {op_ff[3:0], $past(prog_data, 2)}) else $error("jump target wrong");
   a_load_imm_mem: assert property (opc && prog_data == 8'hcd ##1 !prog_data[7] |->
      $stable(flags_ff) [*4] ##0 data_req_ff.wr && da == $past(prog_data, 3) &&
      data_req_ff.wdata == $past(prog_data, 2)) else $error("immediate store wrong");
   a_unsup_flag: assert property (opc && bad_op |-> ##[1:2] unsupported_ff)
      else $error("unsupported opcode not flagged");
endmodule : core_monitor

bind core_addressing_mode_decoder core_monitor #(.START_PC(START_PC)) i_mon (
   .core_clk(core_clk),
   .rst(rst),
   .prog_data(prog_data),
   .data_rdata(data_rdata),
   .prog_req_ff(prog_req_ff),
   .data_req_ff(data_req_ff),
   .flags_ff(flags_ff),
   .acc_ff(acc_ff),
   .unsupported_ff(unsupported_ff)
);

// file: mem_model.sv
`timescale 1ns/1ps
module mem_model (
   input wire logic core_clk,
   input wire core_pkg::prog_req_type prog_req_ff,
   input wire core_pkg::data_req_type data_req_ff,
   output logic [7:0] prog_data,
   output logic [7:0] data_rdata
);
   logic [7:0] pmem [4096];
   logic [7:0] dmem [256];
   initial begin
      prog_data = 8'he0;
      data_rdata = 8'h00;
   end
   // One-cycle latency, no wait states
   always @(posedge core_clk) begin
      prog_data <= pmem[prog_req_ff.addr];
      if (data_req_ff.rd)
         data_rdata <= dmem[data_req_ff.addr];
      else
         data_rdata <= ~data_rdata; // Stale data must never look valid
      if (data_req_ff.wr)
         dmem[data_req_ff.addr] <= data_req_ff.wdata;
   end
endmodule : mem_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] prog_data;
   logic [7:0] data_rdata;
   core_pkg::prog_req_type prog_req;
   core_pkg::data_req_type data_req;
   core_pkg::flags_type flags;
   logic [7:0] acc;
   logic unsup;
   int failures = 0;
   int comparisons = 0;
   int seed = 32'h967f;
   int unsup_cnt = 0;
   logic [7:0] v1, v2, r, fin;
   logic [2:0] b, b2;

   always #4 core_clk = ~core_clk;
   always @(negedge core_clk)
      if (unsup === 1'b1)
         unsup_cnt++;

   core_addressing_mode_decoder i_dut (.core_clk(core_clk), .rst(rst),
      .prog_data(prog_data), .data_rdata(data_rdata), .prog_req_ff(prog_req),
      .data_req_ff(data_req), .flags_ff(flags), .acc_ff(acc), .unsupported_ff(unsup));
   mem_model i_mem (.core_clk(core_clk), .prog_req_ff(prog_req), .data_req_ff(data_req),
      .prog_data(prog_data), .data_rdata(data_rdata));

   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_byte

   task automatic tally_and_finish;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   function automatic logic [7:0] bit_fin(input logic [7:0] v, input logic [2:0] s,
         input logic [2:0] c);
      return (v | (8'h01 << s)) & ~(8'h01 << c);
   endfunction : bit_fin

   task automatic put8(input int a, input logic [63:0] w);
      for (int i = 0; i < 8; i++)
         i_mem.pmem[a + i] = w[63 - 8 * i -: 8];
   endtask : put8

   // Unused program space reads as no-operation
   task automatic reset_on;
      @(negedge core_clk);
      rst = 1'b1;
      unsup_cnt = 0;
      for (int i = 0; i < 4096; i++)
         i_mem.pmem[i] = 8'he0;
   endtask : reset_on

   // Program ends in a jump to itself at halt
   task automatic run(input logic [11:0] halt);
      int hits;
      hits = 0;
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      for (int i = 0; i < 300 && hits < 4; i++) begin
         @(negedge core_clk);
         if (prog_req.addr === halt)
            hits++;
      end
      if (hits < 4) begin
         failures++;
         tally_and_finish();
      end
      repeat (2) @(negedge core_clk);
   endtask : run

   initial begin
      for (int n = 0; n < 4; n++) begin
         v1 = n == 0 ? 8'h00 : 8'($random(seed));
         v2 = n == 0 ? 8'hff : 8'($random(seed));
         reset_on();
         put8(0, {8'hcc, 8'h20, 8'hc4, 8'hcd, 8'h20, v1, 8'hcc, 8'h00});
         put8(8, {8'hca, 8'hc9, 8'h40, 8'hcc, 8'h30, 8'hc5, 8'hcd, 8'h30});
         put8(16, {v2, 8'hda, 8'hc7, 8'hcc, 8'h00, 8'hc3, 8'hc9, 8'h41});
         put8(24, {8'hc8, 8'h40, 8'h80, 8'h1a, 32'he0e0e0e0});
         run(12'h01a);
         cmp_byte("acc", v1, acc);
         cmp_byte("flags", {6'h00, v1 == 8'h00, 1'b0}, {6'h00, flags});
         cmp_byte("ptr_one", v1, i_mem.dmem[8'h40]);
         cmp_byte("ptr_two", v2, i_mem.dmem[8'h41]);
         cmp_byte("imm_mem", v2, i_mem.dmem[8'h30]);
      end
      for (int n = 0; n < 4; n++) begin
         r = n == 0 ? 8'h00 : 8'($random(seed));
         b = n == 0 ? 3'h7 : 3'($random(seed));
         b2 = n == 0 ? 3'h7 : 3'($random(seed));
         fin = bit_fin(r, b, b2);
         reset_on();
         i_mem.dmem[8'h51] = 8'h5a;
         put8(0, {8'hcd, 8'h50, r, 5'h15, b, 8'h50, 5'h14, b2, 8'h50, 8'hcc});
         put8(8, {8'h00, 5'h17, b, 8'h50, 8'h04, 8'hcc, 8'h77, 8'h62, 8'hc9});
         put8(16, {8'h51, 8'h80, 8'h11, 40'he0e0e0e0e0});
         run(12'h011);
         cmp_byte("bit_byte", fin, i_mem.dmem[8'h50]);
         cmp_byte("acc", fin[b] ? 8'h00 : 8'h77, acc);
         cmp_byte("flags", {6'h00, fin[b], fin[b]}, {6'h00, flags});
         cmp_byte("rel_skip", fin[b] ? 8'h5a : 8'h77, i_mem.dmem[8'h51]);
      end
      v1 = 8'($random(seed)) | 8'h01;
      reset_on();
      put8(0, {8'h93, 8'ha0, 8'he0, 8'hf0, 8'h85, 8'hc0, 16'he0e0});
      put8(12'h3a0, {8'h93, 8'hb0, 8'he1, 40'he0e0e0e0e0});
      put8(12'h3b0, {8'hcc, v1, 8'he2, 40'he0e0e0e0e0});
      put8(12'h5c0, {8'h85, 8'hc4, 8'h85, 8'hc2, 8'hc9, 8'h60, 8'h14, 8'he0});
      run(12'h5c2);
      cmp_byte("call_acc", v1, acc);
      cmp_byte("jump_store", v1, i_mem.dmem[8'h60]);
      cmp_byte("unsup_count", 8'h01, 8'(unsup_cnt));
      // A wrongly taken or missed branch runs the byte at 8 and clears the result
      v1 = 8'($random(seed)) | 8'h01;
      reset_on();
      put8(0, {8'hcc, 8'h48, 8'hc5, 8'hcc, v1, 8'hdb, 8'h21, 8'h41});
      put8(8, {8'hc0, 8'hc6, 8'hcc, 8'h00, 8'hc2, 8'he3, 8'he4, 8'h80});
      put8(16, {8'h0f, 56'he0e0e0e0e0e0e0});
      run(12'h00f);
      cmp_byte("rel_tests", v1, acc);
      cmp_byte("ind_store", v1, i_mem.dmem[8'h48]);
      cmp_byte("inh_clean", 8'h00, 8'(unsup_cnt));
      tally_and_finish();
   end
endmodule : tb
